// ==== hw/cpiu_defines.vh ====
`ifndef CPIU_DEFINES_VH
`define CPIU_DEFINES_VH

// Pin-group opcodes: bits 5..3 pick the group, bits 2..0 the bit source
`define CPIU_GRP_DIR      3'h0
`define CPIU_GRP_OUT      3'h1
`define CPIU_GRP_DRV      3'h2
`define CPIU_GRP_FLT      3'h3

`define CPIU_SRC_C        3'h0
`define CPIU_SRC_ONE      3'h1
`define CPIU_SRC_ZERO     3'h2
`define CPIU_SRC_NC       3'h3
`define CPIU_SRC_NOT      3'h4
`define CPIU_SRC_NZ       3'h5
`define CPIU_SRC_RND      3'h6
`define CPIU_SRC_Z        3'h7

// Other opcodes
`define CPIU_OP_TEST      6'h20
`define CPIU_OP_TESTN     6'h21
`define CPIU_OP_ACK       6'h22
`define CPIU_OP_SCP_RD    6'h23
`define CPIU_OP_SCP_SET   6'h24
`define CPIU_OP_RD        6'h25
`define CPIU_OP_RQ        6'h26
`define CPIU_OP_DACS      6'h27
`define CPIU_OP_MODE      6'h28
`define CPIU_OP_WX        6'h29
`define CPIU_OP_WY        6'h2A
`define CPIU_OP_QUEUE_VALUE_PREFIX      6'h2B

// Flag combine operations for pin tests
`define CPIU_FOP_WR       2'h0
`define CPIU_FOP_OR       2'h1
`define CPIU_FOP_AND      2'h2
`define CPIU_FOP_XOR      2'h3

// Operand fields
`define CPIU_PIN_LSB      0
`define CPIU_PIN_MSB      5
`define CPIU_CNT_LSB      6
`define CPIU_CNT_MSB      10
`define CPIU_SCP_EN_BIT   6
`define CPIU_SCP_BASE_LSB 2
`define CPIU_SCP_BASE_MSB 5

// Register byte offsets
`define CPIU_REG_CTRL     8'h00
`define CPIU_REG_STATUS   8'h04
`define CPIU_REG_DIR_A    8'h08
`define CPIU_REG_DIR_B    8'h0C
`define CPIU_REG_OUT_A    8'h10
`define CPIU_REG_OUT_B    8'h14
`define CPIU_REG_DAC      8'h18
`define CPIU_CTRL_EN_BIT  0
`define CPIU_CTRL_RST     1'h1

`define CPIU_RESP_OKAY    2'h0
`define CPIU_RESP_SLVERR  2'h2

`endif

// ==== hw/cpiu_span_mask.v ====
`timescale 1ns/1ps
module cpiu_span_mask (
  input  wire [5:0]  i_base,
  input  wire [4:0]  i_count,
  output wire [63:0] o_mask
);
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi = gi + 1) begin : g_pin
      localparam [5:0] PIN_IDX = gi;
      wire [4:0] local_idx;
      wire [4:0] offset;
      assign local_idx = PIN_IDX[4:0];
      // [RULE2] Wrap in port
      assign offset = local_idx - i_base[4:0];
      // [RULE1] Span membership
      assign o_mask[gi] = (PIN_IDX[5] == i_base[5]) && (offset <= i_count);
    end
  endgenerate
endmodule

// ==== hw/cpiu_core.v ====
// How it works
// [RULE1] First pin from operand bits 5..0, extra pin count from bits 10..6.
// [RULE2] Spans past a port's last pin wrap to that port's first pin.
// [RULE3] A queued prefix value replaces bits 10..6 as the following count.
// [RULE4] Direction variants write C, 1, 0, !C, toggle, !Z, random or Z.
// [RULE5] With both-flag option, C and Z take the base pin's new direction.
// [RULE6] Output variants write output bits the same ways, directions unchanged.
// [RULE7] Drive variants set outputs likewise and force directions to one.
// [RULE8] Float variants set outputs likewise and clear directions to zero.
// [RULE9] With both-flag option, C and Z take the base pin's new output.
// [RULE10] Pin test writes, ORs, ANDs or XORs the input bit into C or Z.
// [RULE11] Inverted pin test does the same with the complemented input.
// [RULE12] Acknowledge pulses every smart pin of the source span.
// [RULE13] Sampler read packs four samples, channel 3 high to channel 0 low.
// [RULE14] Result read returns pin result, acknowledges it, optional modal carry.
// [RULE15] Quiet result read does the same without acknowledging.
// [RULE16] DAC set loads four byte channels from one word.
// [RULE17] Sampler setup takes enable from bit 6 and pin base from bits 5..2.
// [RULE18] Mode write loads the mode of every span pin and acknowledges them.
// [RULE19] X and Y writes load parameters of every span pin with acknowledge.
// [RULE20] Every instruction takes two clocks from acceptance to completion.
// [RULE21] Random variants take one independent random bit per pin.
`timescale 1ns/1ps
`include "cpiu_defines.vh"
module cpiu_core (
  input  wire        i_mclk,
  input  wire        i_rst_n,
  // Instruction side
  input  wire        i_ins_valid,
  output wire        o_ins_ready,
  input  wire [5:0]  i_ins_op,
  input  wire [31:0] i_ins_d,
  input  wire [31:0] i_ins_s,
  input  wire        i_ins_wc,
  input  wire        i_ins_wz,
  input  wire [1:0]  i_ins_fop,
  input  wire        i_flag_c,
  input  wire        i_flag_z,
  input  wire [63:0] i_rnd,
  output reg         o_done,
  output reg  [31:0] o_res_data,
  output reg         o_res_we,
  output reg         o_flag_c,
  output reg         o_flag_z,
  output reg         o_flag_c_we,
  output reg         o_flag_z_we,
  // Pin side
  input  wire [63:0] i_pin_in,
  output wire [63:0] o_pin_dir,
  output wire [63:0] o_pin_out,
  output reg  [63:0] o_sp_mode_we,
  output reg  [63:0] o_sp_x_we,
  output reg  [63:0] o_sp_y_we,
  output reg  [63:0] o_sp_ack,
  output reg  [31:0] o_sp_wdata,
  output wire [5:0]  o_sp_rd_sel,
  input  wire [31:0] i_sp_result,
  input  wire        i_sp_modal_c,
  output reg  [31:0] o_dac,
  output reg         o_scp_en,
  output reg  [3:0]  o_scp_base,
  input  wire [31:0] i_scp_samples,
  // AXI4-Lite slave
  input  wire [7:0]  i_s_axi_awaddr,
  input  wire [2:0]  i_s_axi_awprot,
  input  wire        i_s_axi_awvalid,
  output wire        o_s_axi_awready,
  input  wire [31:0] i_s_axi_wdata,
  input  wire [3:0]  i_s_axi_wstrb,
  input  wire        i_s_axi_wvalid,
  output wire        o_s_axi_wready,
  output reg  [1:0]  o_s_axi_bresp,
  output reg         o_s_axi_bvalid,
  input  wire        i_s_axi_bready,
  input  wire [7:0]  i_s_axi_araddr,
  input  wire [2:0]  i_s_axi_arprot,
  input  wire        i_s_axi_arvalid,
  output wire        o_s_axi_arready,
  output reg  [31:0] o_s_axi_rdata,
  output reg  [1:0]  o_s_axi_rresp,
  output reg         o_s_axi_rvalid,
  input  wire        i_s_axi_rready
);
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_EXEC = 2'h2;

  reg  [1:0]  st_q;
  reg  [5:0]  op_q;
  reg  [31:0] d_q;
  reg  [31:0] s_q;
  reg         wc_q;
  reg         wz_q;
  reg  [1:0]  fop_q;
  reg         c_q;
  reg         z_q;
  reg  [5:0]  base_q;
  reg  [4:0]  cnt_q;
  reg         q_pend_q;
  reg  [31:0] q_val_q;
  reg  [63:0] dir_q;
  reg  [63:0] out_q;
  reg         ctrl_en_q;
  wire [63:0] span;
  wire        take;
  wire        exec;
  wire        is_pin_grp;
  wire        is_smart;
  wire [2:0]  grp;
  reg  [63:0] src_vec;
  reg  [63:0] dir_d;
  reg  [63:0] out_d;
  reg  [63:0] pin_sel;
  reg         test_bit;
  reg         test_new;
  reg         test_old;

  assign o_ins_ready = st_q[0] & ctrl_en_q;
  assign take        = i_ins_valid & o_ins_ready;
  assign exec        = st_q[1];
  assign grp         = op_q[5:3];
  assign is_pin_grp  = ~op_q[5];
  assign is_smart    = (i_ins_op == `CPIU_OP_ACK) || (i_ins_op == `CPIU_OP_MODE) ||
                       (i_ins_op == `CPIU_OP_WX) || (i_ins_op == `CPIU_OP_WY);
  assign o_pin_dir   = dir_q;
  assign o_pin_out   = out_q;
  assign o_sp_rd_sel = s_q[5:0];

  cpiu_span_mask u_span (
    .i_base  (base_q),
    .i_count (cnt_q),
    .o_mask  (span)
  );

  // [RULE20] Accept then execute
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: if (take) st_q <= ST_EXEC;
        ST_EXEC: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      op_q   <= 6'h00;
      d_q    <= 32'h00000000;
      s_q    <= 32'h00000000;
      wc_q   <= 1'h0;
      wz_q   <= 1'h0;
      fop_q  <= 2'h0;
      c_q    <= 1'h0;
      z_q    <= 1'h0;
      base_q <= 6'h00;
      cnt_q  <= 5'h00;
    end else if (take) begin
      op_q   <= i_ins_op;
      d_q    <= i_ins_d;
      s_q    <= i_ins_s;
      wc_q   <= i_ins_wc;
      wz_q   <= i_ins_wz;
      fop_q  <= i_ins_fop;
      c_q    <= i_flag_c;
      z_q    <= i_flag_z;
      // [RULE1] Span from operand
      base_q <= is_smart ? i_ins_s[`CPIU_PIN_MSB:`CPIU_PIN_LSB] : i_ins_d[`CPIU_PIN_MSB:`CPIU_PIN_LSB];
      // [RULE3] Prefix count override
      if (q_pend_q) begin
        cnt_q <= q_val_q[4:0];
      end else if (is_smart) begin
        cnt_q <= i_ins_s[`CPIU_CNT_MSB:`CPIU_CNT_LSB];
      end else begin
        cnt_q <= i_ins_d[`CPIU_CNT_MSB:`CPIU_CNT_LSB];
      end
    end
  end

  // [RULE3] Prefix lasts one instruction
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      q_pend_q <= 1'h0;
      q_val_q  <= 32'h00000000;
    end else if (exec) begin
      q_pend_q <= (op_q == `CPIU_OP_QUEUE_VALUE_PREFIX);
      if (op_q == `CPIU_OP_QUEUE_VALUE_PREFIX) q_val_q <= d_q;
    end
  end

  always @* begin
    // [RULE4] Bit sources, [RULE21] per-pin random bit
    case (op_q[2:0])
      `CPIU_SRC_C:    src_vec = {64{c_q}};
      `CPIU_SRC_ONE:  src_vec = {64{1'b1}};
      `CPIU_SRC_ZERO: src_vec = 64'h0000000000000000;
      `CPIU_SRC_NC:   src_vec = {64{~c_q}};
      `CPIU_SRC_NOT:  src_vec = (grp == `CPIU_GRP_DIR) ? ~dir_q : ~out_q;
      `CPIU_SRC_NZ:   src_vec = {64{~z_q}};
      `CPIU_SRC_RND:  src_vec = i_rnd;
      default:        src_vec = {64{z_q}};
    endcase
    dir_d = dir_q;
    out_d = out_q;
    case (grp)
      `CPIU_GRP_DIR: dir_d = (dir_q & ~span) | (src_vec & span);
      // [RULE6] Outputs only
      `CPIU_GRP_OUT: out_d = (out_q & ~span) | (src_vec & span);
      // [RULE7] Drive forces direction
      `CPIU_GRP_DRV: begin
        out_d = (out_q & ~span) | (src_vec & span);
        dir_d = dir_q | span;
      end
      // [RULE8] Float clears direction
      `CPIU_GRP_FLT: begin
        out_d = (out_q & ~span) | (src_vec & span);
        dir_d = dir_q & ~span;
      end
      default: begin
        dir_d = dir_q;
        out_d = out_q;
      end
    endcase
    pin_sel = 64'h0000000000000000;
    pin_sel[s_q[5:0]] = 1'b1;
    // [RULE11] Inverted input on test
    test_bit = i_pin_in[d_q[5:0]] ^ (op_q == `CPIU_OP_TESTN);
    test_old = wc_q ? c_q : z_q;
    // [RULE10] Combine into flag
    case (fop_q)
      `CPIU_FOP_WR:  test_new = test_bit;
      `CPIU_FOP_OR:  test_new = test_old | test_bit;
      `CPIU_FOP_AND: test_new = test_old & test_bit;
      default:       test_new = test_old ^ test_bit;
    endcase
  end

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      dir_q <= 64'h0000000000000000;
      out_q <= 64'h0000000000000000;
    end else if (exec && is_pin_grp) begin
      dir_q <= dir_d;
      out_q <= out_d;
    end
  end

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_done       <= 1'h0;
      o_res_data   <= 32'h00000000;
      o_res_we     <= 1'h0;
      o_flag_c     <= 1'h0;
      o_flag_z     <= 1'h0;
      o_flag_c_we  <= 1'h0;
      o_flag_z_we  <= 1'h0;
      o_sp_mode_we <= 64'h0000000000000000;
      o_sp_x_we    <= 64'h0000000000000000;
      o_sp_y_we    <= 64'h0000000000000000;
      o_sp_ack     <= 64'h0000000000000000;
      o_sp_wdata   <= 32'h00000000;
      o_dac        <= 32'h00000000;
      o_scp_en     <= 1'h0;
      o_scp_base   <= 4'h0;
    end else begin
      o_done       <= exec;
      o_res_we     <= 1'h0;
      o_flag_c_we  <= 1'h0;
      o_flag_z_we  <= 1'h0;
      o_sp_mode_we <= 64'h0000000000000000;
      o_sp_x_we    <= 64'h0000000000000000;
      o_sp_y_we    <= 64'h0000000000000000;
      o_sp_ack     <= 64'h0000000000000000;
      if (exec) begin
        if (is_pin_grp) begin
          if (wc_q && wz_q) begin
            o_flag_c_we <= 1'h1;
            o_flag_z_we <= 1'h1;
            if (grp == `CPIU_GRP_DIR) begin
              // [RULE5] Flags from direction
              o_flag_c <= dir_d[base_q];
              o_flag_z <= dir_d[base_q];
            end else begin
              // [RULE9] Flags from output
              o_flag_c <= out_d[base_q];
              o_flag_z <= out_d[base_q];
            end
          end
        end else begin
          case (op_q)
            `CPIU_OP_TEST, `CPIU_OP_TESTN: begin
              o_flag_c_we <= wc_q;
              o_flag_z_we <= wz_q & ~wc_q;
              o_flag_c    <= test_new;
              o_flag_z    <= test_new;
            end
            // [RULE12] Span acknowledge
            `CPIU_OP_ACK: o_sp_ack <= span;
            `CPIU_OP_SCP_RD: begin
              // [RULE13] Sample packing
              o_res_data <= {i_scp_samples[31:24], i_scp_samples[23:16], i_scp_samples[15:8], i_scp_samples[7:0]};
              o_res_we   <= 1'h1;
            end
            `CPIU_OP_SCP_SET: begin
              // [RULE17] Sampler enable and base
              o_scp_en   <= d_q[`CPIU_SCP_EN_BIT];
              o_scp_base <= d_q[`CPIU_SCP_BASE_MSB:`CPIU_SCP_BASE_LSB];
            end
            `CPIU_OP_RD, `CPIU_OP_RQ: begin
              // [RULE14] Result into destination
              o_res_data  <= i_sp_result;
              o_res_we    <= 1'h1;
              o_flag_c_we <= wc_q;
              o_flag_c    <= i_sp_modal_c;
              // [RULE15] Quiet read skips acknowledge
              if (op_q == `CPIU_OP_RD) o_sp_ack <= pin_sel;
            end
            // [RULE16] DAC channels
            `CPIU_OP_DACS: o_dac <= {d_q[31:24], d_q[23:16], d_q[15:8], d_q[7:0]};
            `CPIU_OP_MODE: begin
              // [RULE18] Mode load with acknowledge
              o_sp_mode_we <= span;
              o_sp_ack     <= span;
              o_sp_wdata   <= d_q;
            end
            `CPIU_OP_WX, `CPIU_OP_WY: begin
              // [RULE19] Parameter load with acknowledge
              o_sp_x_we  <= (op_q == `CPIU_OP_WX) ? span : 64'h0000000000000000;
              o_sp_y_we  <= (op_q == `CPIU_OP_WY) ? span : 64'h0000000000000000;
              o_sp_ack   <= span;
              o_sp_wdata <= d_q;
            end
            default: o_res_we <= 1'h0;
          endcase
        end
      end
    end
  end

  // AXI4-Lite write path
  reg        aw_held_q;
  reg [7:0]  aw_addr_q;
  reg        w_held_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  wire       wr_fire;

  assign o_s_axi_awready = ~aw_held_q & ~o_s_axi_bvalid;
  assign o_s_axi_wready  = ~w_held_q & ~o_s_axi_bvalid;
  assign wr_fire         = aw_held_q & w_held_q & ~o_s_axi_bvalid;

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      aw_held_q      <= 1'h0;
      aw_addr_q      <= 8'h00;
      w_held_q       <= 1'h0;
      w_data_q       <= 32'h00000000;
      w_strb_q       <= 4'h0;
      o_s_axi_bvalid <= 1'h0;
      o_s_axi_bresp  <= `CPIU_RESP_OKAY;
      ctrl_en_q      <= `CPIU_CTRL_RST;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_held_q <= 1'h1;
        aw_addr_q <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_held_q <= 1'h1;
        w_data_q <= i_s_axi_wdata;
        w_strb_q <= i_s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q      <= 1'h0;
        w_held_q       <= 1'h0;
        o_s_axi_bvalid <= 1'h1;
        if (aw_addr_q == `CPIU_REG_CTRL) begin
          o_s_axi_bresp <= `CPIU_RESP_OKAY;
          if (w_strb_q[0]) ctrl_en_q <= w_data_q[`CPIU_CTRL_EN_BIT];
        end else if (aw_addr_q <= `CPIU_REG_DAC && aw_addr_q[1:0] == 2'h0) begin
          o_s_axi_bresp <= `CPIU_RESP_OKAY;
        end else begin
          o_s_axi_bresp <= `CPIU_RESP_SLVERR;
        end
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'h0;
      end
    end
  end

  // AXI4-Lite read path
  assign o_s_axi_arready = ~o_s_axi_rvalid;

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_s_axi_rvalid <= 1'h0;
      o_s_axi_rdata  <= 32'h00000000;
      o_s_axi_rresp  <= `CPIU_RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'h1;
      o_s_axi_rresp  <= `CPIU_RESP_OKAY;
      case (i_s_axi_araddr)
        `CPIU_REG_CTRL:   o_s_axi_rdata <= {31'h0, ctrl_en_q};
        `CPIU_REG_STATUS: o_s_axi_rdata <= {24'h000000, o_scp_base, o_scp_en, q_pend_q, st_q[1], 1'b0};
        `CPIU_REG_DIR_A:  o_s_axi_rdata <= dir_q[31:0];
        `CPIU_REG_DIR_B:  o_s_axi_rdata <= dir_q[63:32];
        `CPIU_REG_OUT_A:  o_s_axi_rdata <= out_q[31:0];
        `CPIU_REG_OUT_B:  o_s_axi_rdata <= out_q[63:32];
        `CPIU_REG_DAC:    o_s_axi_rdata <= o_dac;
        default: begin
          o_s_axi_rdata <= 32'h00000000;
          o_s_axi_rresp <= `CPIU_RESP_SLVERR;
        end
      endcase
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'h0;
    end
  end
endmodule

// ==== sim/cpiu_monitor.sv ====
`timescale 1ns/1ps
`include "cpiu_defines.vh"
module cpiu_monitor (
  input wire        i_mclk,
  input wire        i_rst_n,
  input wire        i_ins_valid,
  input wire        o_ins_ready,
  input wire [5:0]  i_ins_op,
  input wire [31:0] i_ins_d,
  input wire [31:0] i_ins_s,
  input wire        o_done,
  input wire        o_res_we,
  input wire [31:0] o_res_data,
  input wire [63:0] o_pin_dir,
  input wire [63:0] o_sp_ack,
  input wire [31:0] i_sp_result,
  input wire [31:0] o_dac,
  input wire        o_scp_en
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  wire acc = i_ins_valid & o_ins_ready;
  a_done_two_clk: assert property (acc |=> !o_done ##1 o_done)
    else $error("done not two clocks after accept");
  a_busy_in_exec: assert property (acc |=> !o_ins_ready)
    else $error("instruction taken during execute");
  a_res_with_done: assert property (o_res_we |-> o_done)
    else $error("result write without done");
  a_drive_dir_set: assert property (acc && i_ins_op[5:3] == `CPIU_GRP_DRV |-> ##2 o_pin_dir[$past(i_ins_d[5:0], 2)])
    else $error("drive left base pin undriven");
  a_float_dir_clr: assert property (acc && i_ins_op[5:3] == `CPIU_GRP_FLT |-> ##2 !o_pin_dir[$past(i_ins_d[5:0], 2)])
    else $error("float left base pin driven");
  a_out_dir_kept: assert property (acc && i_ins_op[5:3] == `CPIU_GRP_OUT |-> ##2 o_pin_dir == $past(o_pin_dir))
    else $error("output variant changed directions");
  a_read_ack_pin: assert property (acc && i_ins_op == `CPIU_OP_RD |-> ##2
    o_sp_ack == (64'h1 << $past(i_ins_s[5:0], 2)) && o_res_data == $past(i_sp_result))
    else $error("result read data or acknowledge wrong");
  a_quiet_no_ack: assert property (acc && i_ins_op == `CPIU_OP_RQ |-> ##2 o_sp_ack == 64'h0)
    else $error("quiet read acknowledged");
  a_dac_load: assert property (acc && i_ins_op == `CPIU_OP_DACS |-> ##2 o_dac == $past(i_ins_d, 2))
    else $error("dac values wrong");
  a_scope_enable: assert property (acc && i_ins_op == `CPIU_OP_SCP_SET |-> ##2 o_scp_en == $past(i_ins_d[6], 2))
    else $error("sampler enable wrong");
  c_read: cover property (acc && i_ins_op == `CPIU_OP_RD);
  c_drive: cover property (acc && i_ins_op[5:3] == `CPIU_GRP_DRV);
  c_prefix: cover property (acc && i_ins_op == `CPIU_OP_QUEUE_VALUE_PREFIX);
endmodule
bind cpiu_core cpiu_monitor u_mon (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ins_valid(i_ins_valid),
  .o_ins_ready(o_ins_ready), .i_ins_op(i_ins_op), .i_ins_d(i_ins_d), .i_ins_s(i_ins_s), .o_done(o_done),
  .o_res_we(o_res_we), .o_res_data(o_res_data), .o_pin_dir(o_pin_dir), .o_sp_ack(o_sp_ack),
  .i_sp_result(i_sp_result), .o_dac(o_dac), .o_scp_en(o_scp_en));

// ==== sim/cpiu_pin_model.sv ====
`timescale 1ns/1ps
module cpiu_pin_model (
  input  wire        i_mclk,
  input  wire [63:0] i_pin_dir,
  input  wire [63:0] i_pin_out,
  input  wire [63:0] i_sp_x_we,
  input  wire [31:0] i_sp_wdata,
  input  wire [5:0]  i_sp_rd_sel,
  output wire [63:0] o_pin_in,
  output wire [31:0] o_sp_result,
  output wire        o_sp_modal_c,
  output wire [31:0] o_scp_samples
);
  logic [31:0] x_q [64];
  logic [63:0] pat_q = 64'h0123456789ABCDEF;
  initial for (int p = 0; p < 64; p++) x_q[p] = 32'h0;
  always @(posedge i_mclk) begin
    pat_q <= {pat_q[62:0], pat_q[63] ^ pat_q[62]};
    for (int p = 0; p < 64; p++) if (i_sp_x_we[p]) x_q[p] <= i_sp_wdata;
  end
  // Undriven pins float: pattern changes every cycle
  assign o_pin_in = (i_pin_dir & i_pin_out) | (~i_pin_dir & pat_q);
  // Result and modal bit of selected pin
  assign o_sp_result = x_q[i_sp_rd_sel] ^ {26'h0, i_sp_rd_sel};
  assign o_sp_modal_c = ^x_q[i_sp_rd_sel];
  assign o_scp_samples = pat_q[31:0];
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`include "cpiu_defines.vh"
module tb_top;
  logic        i_mclk = 0, i_rst_n = 0, vld = 0, wc = 0, wz = 0, fl_c = 0, fl_z = 0;
  logic        awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
  logic [5:0]  op = 0;
  logic [1:0]  fop = 0;
  logic [31:0] ind = 0, ins = 0, wdat = 0;
  logic [63:0] rnd = 0;
  logic [7:0]  awa = 0, ara = 0;
  wire         rdy, done, res_we, fc, fz, fcwe, fzwe, mc, scp_en, awr, wr, bv, arr, rv;
  wire  [31:0] res, spw, spr, dac, smp, rdat;
  wire  [63:0] pin_in, pdir, pout, mwe, xwe, ywe, ack;
  wire  [5:0]  sel;
  wire  [3:0]  sbase;
  wire  [1:0]  bresp, rresp;
  int          miscompares = 0, num_checks = 0;
  logic [63:0] dm = 0, om = 0, pinc, rndc;
  logic [31:0] xm [64], smpc, dacm = 0, scpm = 0;
  logic        qp = 0;
  logic [4:0]  qc = 0;
  cpiu_core dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ins_valid(vld), .o_ins_ready(rdy), .i_ins_op(op),
    .i_ins_d(ind), .i_ins_s(ins), .i_ins_wc(wc), .i_ins_wz(wz), .i_ins_fop(fop), .i_flag_c(fl_c),
    .i_flag_z(fl_z), .i_rnd(rnd), .o_done(done), .o_res_data(res), .o_res_we(res_we), .o_flag_c(fc),
    .o_flag_z(fz), .o_flag_c_we(fcwe), .o_flag_z_we(fzwe), .i_pin_in(pin_in), .o_pin_dir(pdir),
    .o_pin_out(pout), .o_sp_mode_we(mwe), .o_sp_x_we(xwe), .o_sp_y_we(ywe), .o_sp_ack(ack),
    .o_sp_wdata(spw), .o_sp_rd_sel(sel), .i_sp_result(spr), .i_sp_modal_c(mc), .o_dac(dac),
    .o_scp_en(scp_en), .o_scp_base(sbase), .i_scp_samples(smp), .i_s_axi_awaddr(awa),
    .i_s_axi_awprot(3'h0), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wdat),
    .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(brdy), .i_s_axi_araddr(ara), .i_s_axi_arprot(3'h0),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rrdy));
  cpiu_pin_model u_pins (.i_mclk(i_mclk), .i_pin_dir(pdir), .i_pin_out(pout), .i_sp_x_we(xwe),
    .i_sp_wdata(spw), .i_sp_rd_sel(sel), .o_pin_in(pin_in), .o_sp_result(spr), .o_sp_modal_c(mc),
    .o_scp_samples(smp));
  always #2.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) rnd <= {$urandom, $urandom};
  task automatic complete_run;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [63:0] span(input logic [5:0] b, input logic [4:0] n);
    span = 64'h0;
    for (int k = 0; k <= n; k++) span[{b[5], 5'(b[4:0] + 5'(k))}] = 1'b1;
  endfunction
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    @(posedge i_mclk);
    awa <= a;
    wdat <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(negedge i_mclk);
      ta = awv & awr;
      tw = wv & wr;
      @(posedge i_mclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while ((awv && !ta) || (wv && !tw));
    while (bv !== 1'b1) @(negedge i_mclk);
    r = bresp;
    @(posedge i_mclk);
    brdy <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_mclk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do @(negedge i_mclk); while (arr !== 1'b1);
    @(posedge i_mclk);
    arv <= 1'b0;
    do @(negedge i_mclk); while (rv !== 1'b1);
    d = rdat;
    r = rresp;
    @(posedge i_mclk);
    rrdy <= 1'b0;
  endtask
  task automatic run(input logic [5:0] o, input logic [31:0] d, s, input logic w1, w2, input logic [1:0] f);
    logic [63:0] m, ea;
    logic [7:0]  sv;
    logic [3:0]  cv;
    logic [4:0]  n;
    logic        c, z, v, b;
    c = 1'($urandom);
    z = 1'($urandom);
    @(posedge i_mclk);
    op <= o;
    ind <= d;
    ins <= s;
    wc <= w1;
    wz <= w2;
    fop <= f;
    fl_c <= c;
    fl_z <= z;
    vld <= 1'b1;
    do @(negedge i_mclk); while (rdy !== 1'b1);
    @(posedge i_mclk);
    vld <= 1'b0;
    @(posedge i_mclk);
    pinc = pin_in;
    rndc = rnd;
    smpc = smp;
    @(negedge i_mclk);
    chk(done, 1'b1);
    n = qp ? qc : (o[5] ? s[10:6] : d[10:6]);
    qp = (o == `CPIU_OP_QUEUE_VALUE_PREFIX);
    qc = d[4:0];
    m = span(o[5] ? s[5:0] : d[5:0], n);
    if (!o[5]) begin
      for (int p = 0; p < 64; p++) if (m[p]) begin
        b = (o[4:3] == 2'h0) ? dm[p] : om[p];
        sv = {z, rndc[p], !z, !b, !c, 1'b0, 1'b1, c};
        v = sv[o[2:0]];
        if (o[4:3] != 2'h0) om[p] = v;
        dm[p] = o[4] ? !o[3] : (o[3] ? dm[p] : v);
      end
      v = (o[4:3] == 2'h0) ? dm[d[5:0]] : om[d[5:0]];
      if (w1 && w2) chk({fc, fz}, {v, v});
    end
    if (o == `CPIU_OP_TEST || o == `CPIU_OP_TESTN) begin
      b = pinc[d[5:0]] ^ o[0];
      v = w1 ? c : z;
      cv = {v ^ b, v & b, v | b, b};
      chk(w1 ? fc : fz, cv[f]);
    end
    if (o == `CPIU_OP_WX) for (int p = 0; p < 64; p++) if (m[p]) xm[p] = d;
    if (o == `CPIU_OP_RD || o == `CPIU_OP_RQ) begin
      chk(res, xm[s[5:0]] ^ {26'h0, s[5:0]});
      if (w1) chk(fc, ^xm[s[5:0]]);
    end
    if (o == `CPIU_OP_DACS) dacm = d;
    if (o == `CPIU_OP_SCP_SET) scpm = {24'h0, d[5:2], d[6], 3'h0};
    if (o == `CPIU_OP_SCP_RD) chk(res, {smpc[31:24], smpc[23:16], smpc[15:8], smpc[7:0]});
    ea = (o == `CPIU_OP_RD) ? 64'h1 << s[5:0] : 64'h0;
    if (o == `CPIU_OP_ACK || o == `CPIU_OP_MODE || o == `CPIU_OP_WX || o == `CPIU_OP_WY) ea = m;
    chk(ack, ea);
    chk(mwe, (o == `CPIU_OP_MODE) ? m : 64'h0);
    chk(xwe, (o == `CPIU_OP_WX) ? m : 64'h0);
    chk(ywe, (o == `CPIU_OP_WY) ? m : 64'h0);
    if (o == `CPIU_OP_MODE || o == `CPIU_OP_WX || o == `CPIU_OP_WY) chk(spw, d);
    chk(pdir, dm);
    chk(pout, om);
    chk({dac, sbase, scp_en}, {dacm, scpm[7:3]});
    b = (o == `CPIU_OP_TEST || o == `CPIU_OP_TESTN);
    v = (o == `CPIU_OP_RD || o == `CPIU_OP_RQ);
    cv = {1'b0, v || o == `CPIU_OP_SCP_RD, o[5] ? w1 && (b || v) : w1 && w2, o[5] ? b && w2 && !w1 : w1 && w2};
    chk({res_we, fcwe, fzwe}, cv[2:0]);
  endtask
  initial begin
    #(20000 * 5);
    miscompares++;
    complete_run();
  end
  initial begin
    logic [31:0] rd;
    logic [1:0]  rr;
    for (int p = 0; p < 64; p++) xm[p] = 32'h0;
    void'($urandom(32'hcf8073ae));
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    axr(`CPIU_REG_CTRL, rd, rr);
    chk({rr, rd}, {`CPIU_RESP_OKAY, 32'h1});
    axr(8'h40, rd, rr);
    chk({rr, rd}, {`CPIU_RESP_SLVERR, 32'h0});
    axw(`CPIU_REG_DIR_A, 32'hFFFFFFFF, rr);
    chk(rr, `CPIU_RESP_OKAY);
    run({`CPIU_GRP_DRV, `CPIU_SRC_ONE}, 32'h05F, 0, 1, 1, 0);
    run(`CPIU_OP_QUEUE_VALUE_PREFIX, 31, 0, 0, 0, 0);
    run({`CPIU_GRP_FLT, `CPIU_SRC_ZERO}, 32'h3F, 0, 1, 1, 0);
    for (int i = 0; i < 96; i++) begin
      if (i % 5 == 0) run(`CPIU_OP_QUEUE_VALUE_PREFIX, $urandom, 0, 0, 0, 0);
      run(6'(i % 32), $urandom & 32'h7FF, 0, i[5], i[5] | i[0], 0);
    end
    for (int i = 0; i < 16; i++) run(i[0] ? `CPIU_OP_TESTN : `CPIU_OP_TEST, $urandom, 0, i[3], 1, i[2:1]);
    run(`CPIU_OP_QUEUE_VALUE_PREFIX, 4, 0, 0, 0, 0);
    run(`CPIU_OP_WX, $urandom, 30, 0, 0, 0);
    run(`CPIU_OP_RD, 0, 31, 1, 0, 0);
    run(`CPIU_OP_RQ, 0, 0, 1, 0, 0);
    run(`CPIU_OP_WY, $urandom, $urandom & 32'h7FF, 0, 0, 0);
    run(`CPIU_OP_MODE, $urandom, 32'h0BE, 0, 0, 0);
    run(`CPIU_OP_ACK, 0, 32'h7FD, 0, 0, 0);
    run(`CPIU_OP_DACS, $urandom, 0, 0, 0, 0);
    run(`CPIU_OP_SCP_SET, $urandom, 0, 0, 0, 0);
    run(`CPIU_OP_SCP_RD, 0, 0, 0, 0, 0);
    axr(`CPIU_REG_DIR_A, rd, rr);
    chk({rr, rd}, {`CPIU_RESP_OKAY, dm[31:0]});
    axr(`CPIU_REG_OUT_B, rd, rr);
    chk(rd, om[63:32]);
    axr(`CPIU_REG_DAC, rd, rr);
    chk(rd, dacm);
    axr(`CPIU_REG_STATUS, rd, rr);
    chk(rd, scpm);
    axw(`CPIU_REG_CTRL, 0, rr);
    @(negedge i_mclk);
    chk(rdy, 1'b0);
    axw(`CPIU_REG_CTRL, 1, rr);
    run(`CPIU_OP_RQ, 0, 31, 1, 0, 0);
    complete_run();
  end
endmodule
